//--- hdl/gci_interp.sv
// Notes on behaviour
// - Parameters carry 32 pins, eight implemented.
// - Parameters little endian, pin zero first.
// - Dedicated pins: any read value, writes ignored.
// - Frame is opcode plus two four-byte parameters.
// - Accepted command replies opcode plus one word.
// - Unknown opcode replies single byte ff.
// - Opcodes 10h-13h read function, direction, level, state.
// - Read opcodes ignore their parameter bytes.
// - Function word cannot change through commands.
// - Updates volatile; reset restores boot values.
// - Function one means general purpose pin.
// - Direction one means output, zero input.
// - Level one means active low.
// - State one means logically active.
// - Opcode 19h masked direction update, returns directions.
// - Opcode 1Ah masked level update, returns levels.
// - Opcode 1Bh masked state update, returns states.
// - Boot default: general purpose input, active low.
// - Control switch disables the command interface.
`timescale 1ns/1ps
`default_nettype none
`include "gci_cfg.svh"

module gci_interp (
  // Clock and reset.
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  // Avalon-MM register slave.
  input  wire logic [3:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  // Command byte stream from the host.
  input  wire logic [7:0]            cmd_data_in,
  input  wire logic                  cmd_valid_in,
  output logic                       cmd_ready_out,
  // Reply byte stream to the host.
  output logic      [7:0]            rsp_data_out,
  output logic                       rsp_valid_out,
  input  wire logic                  rsp_ready_in,
  // Configurable pins.
  input  wire logic [`GCI_NPINS-1:0] pin_in,
  output logic      [`GCI_NPINS-1:0] pin_out,
  output logic      [`GCI_NPINS-1:0] pin_oe_n_out
);

  // Merge new bits into an old word wherever the mask is set.
  function automatic logic [`GCI_NPINS-1:0] merge(
    input logic [`GCI_NPINS-1:0] old_bits,
    input logic [`GCI_NPINS-1:0] mask_bits,
    input logic [`GCI_NPINS-1:0] new_bits
  );
    merge = (old_bits & ~mask_bits) | (new_bits & mask_bits);
  endfunction

  // Widen an eight-pin word to the 32-bit protocol word.
  function automatic logic [31:0] widen(input logic [`GCI_NPINS-1:0] bits);
    widen = {{(32 - `GCI_NPINS){1'b0}}, bits};
  endfunction

  gci_pkg::gci_state_t   state_r;      // Sequencer state.
  gci_pkg::gci_frame_t   frame;        // Frame held by the collector.
  logic                  frame_full;   // Collector holds a whole frame.
  logic                  take;         // Release the held frame.
  logic [`GCI_NPINS-1:0] func_r;       // Function word, general use when set.
  logic [`GCI_NPINS-1:0] dir_r;        // Direction word, output when set.
  logic [`GCI_NPINS-1:0] lvl_r;        // Level word, active low when set.
  logic [`GCI_NPINS-1:0] st_r;         // Stored logical state.
  logic [`GCI_NPINS-1:0] in_state;     // Logical state seen on the pads.
  logic [`GCI_NPINS-1:0] cur_state;    // Reported state of every pin.
  logic                  disable_r;    // Command interface switched off.
  logic [15:0]           good_cnt_r;   // Accepted commands.
  logic [15:0]           bad_cnt_r;    // Rejected commands.
  logic [31:0]           rsp_buf_r;    // Reply bytes still to send.
  logic [3:0]            rsp_cnt_r;    // Reply bytes left including current.
  logic [`GCI_NPINS-1:0] gp_mask;      // Update mask limited to general pins.
  logic [`GCI_NPINS-1:0] dir_nxt;      // Direction after this command.
  logic [`GCI_NPINS-1:0] lvl_nxt;      // Level after this command.
  logic [`GCI_NPINS-1:0] st_nxt;       // State after this command.
  logic [31:0]           word_nxt;     // Reply parameter.
  logic                  known;        // Opcode is recognised.
  logic [31:0]           rd_nxt;       // Read data for the current access.
  logic                  acc;          // Bus access completes this cycle.

  // Collects nine command bytes into one frame.
  gci_frame_rx u_rx (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .byte_in        (cmd_data_in),
    .byte_valid_in  (cmd_valid_in),
    .byte_ready_out (cmd_ready_out),
    .take_in        (take),
    .full_out       (frame_full),
    .frame_out      (frame)
  );

  // Drives and samples the pads.
  gci_pin_bank u_pins (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .func_in      (func_r),
    .dir_in       (dir_r),
    .lvl_in       (lvl_r),
    .state_in     (st_r),
    .pin_in       (pin_in),
    .pin_out      (pin_out),
    .pin_oe_n_out (pin_oe_n_out),
    .in_state_out (in_state)
  );

  // Outputs report their stored state, inputs the logical state sampled at the pad.
  assign cur_state = (dir_r & st_r) | (~dir_r & in_state);

  // Only pins in general use may be changed by a command.
  assign gp_mask = frame.mask[`GCI_NPINS-1:0] & func_r;

  // The frame is released once the sequencer has looked at it.
  assign take = frame_full && (state_r == gci_pkg::GCI_IDLE);

  // Command decode: new settings and the reply word.
  always_comb begin
    dir_nxt  = dir_r;
    lvl_nxt  = lvl_r;
    st_nxt   = st_r;
    word_nxt = 32'h0000_0000;
    known    = 1'b1;
    // Parameter bytes are read only by the update opcodes.
    case (frame.opcode)
      `GCI_OP_GET_FUNC: begin
        word_nxt = widen(func_r);
      end
      `GCI_OP_GET_DIR: begin
        word_nxt = widen(dir_r);
      end
      `GCI_OP_GET_LVL: begin
        word_nxt = widen(lvl_r);
      end
      `GCI_OP_GET_STATE: begin
        word_nxt = widen(cur_state);
      end
      `GCI_OP_SET_DIR: begin
        dir_nxt  = merge(dir_r, gp_mask, frame.value[`GCI_NPINS-1:0]);
        word_nxt = widen(dir_nxt);
      end
      `GCI_OP_SET_LVL: begin
        lvl_nxt  = merge(lvl_r, gp_mask, frame.value[`GCI_NPINS-1:0]);
        word_nxt = widen(lvl_nxt);
      end
      `GCI_OP_SET_STATE: begin
        st_nxt   = merge(st_r, gp_mask, frame.value[`GCI_NPINS-1:0]);
        word_nxt = widen((dir_r & st_nxt) | (~dir_r & in_state));
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // Sequencer: wait for a frame, act on it, send the reply.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= gci_pkg::GCI_IDLE;
    end else begin
      case (state_r)
        gci_pkg::GCI_IDLE: begin
          // A disabled interface swallows frames without a reply.
          if (frame_full && !disable_r) begin
            state_r <= gci_pkg::GCI_EXEC;
          end
        end
        gci_pkg::GCI_EXEC: begin
          state_r <= gci_pkg::GCI_REPLY;
        end
        gci_pkg::GCI_REPLY: begin
          // Return to idle once the last reply byte is taken.
          if (rsp_ready_in && rsp_cnt_r == 4'h1) begin
            state_r <= gci_pkg::GCI_IDLE;
          end
        end
        default: begin
          state_r <= gci_pkg::GCI_IDLE;
        end
      endcase
    end
  end

  // Volatile pin settings, reloaded with boot values on reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_r <= `GCI_BOOT_DIR;
      lvl_r <= `GCI_BOOT_LVL;
      st_r  <= `GCI_BOOT_STATE;
    end else if (state_r == gci_pkg::GCI_EXEC) begin
      dir_r <= dir_nxt;
      lvl_r <= lvl_nxt;
      st_r  <= st_nxt;
    end
  end

  // Reply shifter: first byte is the echoed opcode or the error code.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_data_out  <= 8'h00;
      rsp_valid_out <= 1'b0;
      rsp_buf_r     <= 32'h0000_0000;
      rsp_cnt_r     <= 4'h0;
    end else if (state_r == gci_pkg::GCI_EXEC) begin
      rsp_valid_out <= 1'b1;
      rsp_buf_r     <= word_nxt;
      if (known) begin
        rsp_data_out <= frame.opcode;
        rsp_cnt_r    <= `GCI_REPLY_BYTES;
      end else begin
        rsp_data_out <= `GCI_ERROR_CODE;
        rsp_cnt_r    <= `GCI_ERROR_BYTES;
      end
    end else if (rsp_valid_out && rsp_ready_in) begin
      // Send the parameter low byte first.
      if (rsp_cnt_r == 4'h1) begin
        rsp_valid_out <= 1'b0;
      end else begin
        rsp_data_out <= rsp_buf_r[7:0];
        rsp_buf_r    <= {8'h00, rsp_buf_r[31:8]};
      end
      rsp_cnt_r <= rsp_cnt_r - 4'h1;
    end
  end

  // Command counters, shown to software.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      good_cnt_r <= 16'h0000;
      bad_cnt_r  <= 16'h0000;
    end else if (state_r == gci_pkg::GCI_EXEC) begin
      if (known) begin
        good_cnt_r <= good_cnt_r + 16'h0001;
      end else begin
        bad_cnt_r <= bad_cnt_r + 16'h0001;
      end
    end
  end

  // An access completes in the cycle its waitrequest is low.
  assign acc = (avs_read_in || avs_write_in) && !avs_waitrequest_out;

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address_in)
      `GCI_REG_CTRL: begin
        rd_nxt[`GCI_CTRL_DISABLE] = disable_r;
      end
      `GCI_REG_FUNC: begin
        rd_nxt = widen(func_r);
      end
      `GCI_REG_STATUS: begin
        rd_nxt = {7'h00, state_r != gci_pkg::GCI_IDLE, cur_state, lvl_r, dir_r};
      end
      `GCI_REG_COUNT: begin
        rd_nxt = {bad_cnt_r, good_cnt_r};
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Waitrequest drops for one cycle, one cycle after a request appears.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out    <= avs_read_in ? rd_nxt : 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  // Boot configuration: interface switch and function word.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      disable_r <= `GCI_BOOT_DISABLE;
      func_r    <= `GCI_BOOT_FUNC;
    end else if (acc && avs_write_in && avs_byteenable_in[0]) begin
      // The function word is reachable from software only, never by command.
      if (avs_address_in == `GCI_REG_CTRL) begin
        disable_r <= avs_writedata_in[`GCI_CTRL_DISABLE];
      end else if (avs_address_in == `GCI_REG_FUNC) begin
        func_r <= avs_writedata_in[`GCI_NPINS-1:0];
      end
    end
  end

endmodule  // gci_interp
`default_nettype wire

//--- shared/gci_cfg.svh
`ifndef GCI_CFG_SVH
`define GCI_CFG_SVH

// Pin vector geometry and frame lengths.
`define GCI_NPINS        8
`define GCI_FRAME_BYTES  9
`define GCI_REPLY_BYTES  4'h5
`define GCI_ERROR_BYTES  4'h1
`define GCI_ERROR_CODE   8'hff

// Command opcodes carried in byte 0 of a frame.
`define GCI_OP_GET_FUNC  8'h10
`define GCI_OP_GET_DIR   8'h11
`define GCI_OP_GET_LVL   8'h12
`define GCI_OP_GET_STATE 8'h13
`define GCI_OP_SET_DIR   8'h19
`define GCI_OP_SET_LVL   8'h1a
`define GCI_OP_SET_STATE 8'h1b

// Boot values restored by every reset.
`define GCI_BOOT_FUNC    8'hff
`define GCI_BOOT_DIR     8'h00
`define GCI_BOOT_LVL     8'hff
`define GCI_BOOT_STATE   8'h00
`define GCI_BOOT_DISABLE 1'b0

// Register byte offsets on the bus.
`define GCI_REG_CTRL     4'h0
`define GCI_REG_FUNC     4'h4
`define GCI_REG_STATUS   4'h8
`define GCI_REG_COUNT    4'hc

// Field position in the control register.
`define GCI_CTRL_DISABLE 0

`endif

//--- shared/gci_pkg.sv
`default_nettype none
package gci_pkg;

  // One collected command frame, parameters already little endian.
  typedef struct packed {
    logic [7:0]  opcode;  // Command byte.
    logic [31:0] mask;    // First parameter.
    logic [31:0] value;   // Second parameter.
  } gci_frame_t;

  // Sequencer states of the interpreter.
  typedef enum logic [1:0] {
    GCI_IDLE  = 2'b00,
    GCI_EXEC  = 2'b01,
    GCI_REPLY = 2'b10
  } gci_state_t;

endpackage
`default_nettype wire

//--- hdl/gci_frame_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "gci_cfg.svh"

module gci_frame_rx (
  // Clock and reset.
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  // Incoming command bytes.
  input  wire logic [7:0]        byte_in,
  input  wire logic              byte_valid_in,
  output logic                   byte_ready_out,
  // Collected frame towards the sequencer.
  input  wire logic              take_in,
  output logic                   full_out,
  output gci_pkg::gci_frame_t    frame_out
);

  logic [7:0] byte_r [0:`GCI_FRAME_BYTES-1];  // Frame storage, indexed by position.
  logic [3:0] idx_r;                           // Position of the next byte.
  logic       hit;                             // A byte is taken this cycle.

  assign hit = byte_valid_in && byte_ready_out;

  // Byte storage: each accepted byte lands at its frame position.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `GCI_FRAME_BYTES; i++) begin
        byte_r[i] <= 8'h00;
      end
    end else if (hit) begin
      byte_r[idx_r] <= byte_in;
    end
  end

  // Position counter and full flag; the full frame blocks new bytes.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_r          <= 4'h0;
      full_out       <= 1'b0;
      byte_ready_out <= 1'b1;
    end else if (hit && idx_r == 4'(`GCI_FRAME_BYTES - 1)) begin
      idx_r          <= 4'h0;
      full_out       <= 1'b1;
      byte_ready_out <= 1'b0;
    end else if (hit) begin
      idx_r <= idx_r + 4'h1;
    end else if (take_in) begin
      full_out       <= 1'b0;
      byte_ready_out <= 1'b1;
    end
  end

  // Parameters are little endian: bytes 1 and 5 hold pins 0 to 7.
  assign frame_out.opcode = byte_r[0];
  assign frame_out.mask   = {byte_r[4], byte_r[3], byte_r[2], byte_r[1]};
  assign frame_out.value  = {byte_r[8], byte_r[7], byte_r[6], byte_r[5]};

endmodule  // gci_frame_rx
`default_nettype wire

//--- hdl/gci_pin_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "gci_cfg.svh"

module gci_pin_bank (
  // Clock and reset.
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  // Pin configuration.
  input  wire logic [`GCI_NPINS-1:0] func_in,
  input  wire logic [`GCI_NPINS-1:0] dir_in,
  input  wire logic [`GCI_NPINS-1:0] lvl_in,
  input  wire logic [`GCI_NPINS-1:0] state_in,
  // Pads and sampled logical state.
  input  wire logic [`GCI_NPINS-1:0] pin_in,
  output logic      [`GCI_NPINS-1:0] pin_out,
  output logic      [`GCI_NPINS-1:0] pin_oe_n_out,
  output logic      [`GCI_NPINS-1:0] in_state_out
);

  genvar g;

  // One identical slice per configurable pin.
  generate
    for (g = 0; g < `GCI_NPINS; g++) begin : g_pin
      // Drive only general purpose outputs; others stay undriven.
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_out[g]      <= 1'b0;
          pin_oe_n_out[g] <= 1'b1;
          in_state_out[g] <= 1'b0;
        end else begin
          pin_out[g]      <= state_in[g] ^ ~lvl_in[g] ^ 1'b1;
          pin_oe_n_out[g] <= ~(func_in[g] & dir_in[g]);
          in_state_out[g] <= pin_in[g] ^ lvl_in[g];
        end
      end
    end
  endgenerate

endmodule  // gci_pin_bank
`default_nettype wire

//--- tb/gci_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gci_chk (
  // Clock and reset.
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  // Register bus.
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic        avs_waitrequest_out,
  // Byte streams and pads.
  input wire logic [7:0]  cmd_data_in,
  input wire logic        cmd_valid_in,
  input wire logic        cmd_ready_out,
  input wire logic [7:0]  rsp_data_out,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_ready_in,
  input wire logic [7:0]  pin_oe_n_out
);
  logic [3:0] nb_r;  // Command bytes taken in the current frame.
  logic [2:0] ri_r;  // Reply bytes taken in the current reply.
  logic [7:0] op_r;  // Opcode of the current frame.
  logic       dis_r; // Copy of the interface disable bit.
  wire cmd_hs = cmd_valid_in && cmd_ready_out;
  wire rsp_hs = rsp_valid_out && rsp_ready_in;
  wire op_ok = op_r inside {[8'h10:8'h13], [8'h19:8'h1b]};
  // Frame position tracking.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nb_r <= 4'h0;
      op_r <= 8'h00;
    end else if (cmd_hs) begin
      nb_r <= (nb_r == 4'h8) ? 4'h0 : nb_r + 4'h1;
      op_r <= (nb_r == 4'h0) ? cmd_data_in : op_r;
    end
  end
  // Reply position tracking; an error reply is one byte long.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ri_r <= 3'h0;
    end else if (rsp_hs) begin
      ri_r <= ((ri_r == 3'h0 && rsp_data_out == 8'hff) || ri_r == 3'h4) ? 3'h0 : ri_r + 3'h1;
    end
  end
  // Disable bit follows completed writes to the control word.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dis_r <= 1'b0;
    end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0
                 && avs_byteenable_in[0]) begin
      dis_r <= avs_writedata_in[0];
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_frame_end;
    cmd_hs && nb_r == 4'h8 && !dis_r;
  endsequence
  sequence s_first_byte;
    rsp_valid_out && rsp_data_out == (op_ok ? op_r : 8'hff);
  endsequence
  chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus request not answered");
  chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  chk_reply_start: assert property (s_frame_end |-> ##[1:3] s_first_byte)
    else $error("wrong or missing first reply byte");
  chk_ready_drop: assert property (s_frame_end |=> !cmd_ready_out)
    else $error("ready stayed high after full frame");
  chk_reply_hold: assert property (rsp_valid_out && !rsp_ready_in
    |=> rsp_valid_out && $stable(rsp_data_out)) else $error("reply byte dropped");
  chk_error_len: assert property (rsp_hs && ri_r == 3'h0 && rsp_data_out == 8'hff
    |=> !rsp_valid_out) else $error("error reply longer than one byte");
  chk_reply_len: assert property (rsp_hs && ri_r == 3'h4 |=> !rsp_valid_out)
    else $error("reply longer than five bytes");
  chk_reply_run: assert property (rsp_hs && ri_r != 3'h4 && !(ri_r == 3'h0
    && rsp_data_out == 8'hff) |=> rsp_valid_out) else $error("reply cut short");
  chk_upper_zero: assert property (rsp_valid_out && ri_r >= 3'h2 |-> rsp_data_out == 8'h00)
    else $error("unimplemented pin bits not zero");
  chk_boot_pins: assert property ($rose(rst_n_in) |-> pin_oe_n_out == 8'hff)
    else $error("pins driven after reset");
endmodule // gci_chk
bind gci_interp gci_chk u_chk (.sys_clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .cmd_data_in,
  .cmd_valid_in, .cmd_ready_out, .rsp_data_out, .rsp_valid_out, .rsp_ready_in, .pin_oe_n_out);
`default_nettype wire

//--- tb/gci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gci_host_model (
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // Control from the bench; the frame is opcode, mask, value.
  input  wire logic        go_in,
  input  wire logic        quit_in,
  input  wire logic        slow_in,
  input  wire logic [71:0] frame_in,
  output logic             done_out,
  output logic [39:0]      rep_out,
  output logic [2:0]       nrep_out,
  // Byte streams.
  output logic [7:0]       cmd_data_out,
  output logic             cmd_valid_out,
  input  wire logic        cmd_ready_in,
  input  wire logic [7:0]  rsp_data_in,
  input  wire logic        rsp_valid_in,
  output logic             rsp_ready_out
);
  logic [71:0] sh_r;   // Bytes still to send, lowest first.
  logic [3:0]  cnt_r;  // Bytes sent of the current frame.
  logic        busy_r; // A command is out and its reply is not yet in.
  // Sender: a whole frame per command; the data line toggles when idle.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_r <= '0;
      cnt_r <= 4'h0;
      cmd_valid_out <= 1'b0;
      cmd_data_out <= 8'h00;
    end else if (go_in && !busy_r) begin
      sh_r <= {8'h00, frame_in[31:0], frame_in[63:32]};
      cmd_data_out <= frame_in[71:64];
      cmd_valid_out <= 1'b1;
      cnt_r <= 4'h0;
    end else if (cmd_valid_out && cmd_ready_in) begin
      cmd_valid_out <= cnt_r != 4'h8;
      cmd_data_out <= (cnt_r == 4'h8) ? ~cmd_data_out : sh_r[7:0];
      sh_r <= sh_r >> 8;
      cnt_r <= cnt_r + 4'h1;
    end else if (!cmd_valid_out) begin
      cmd_data_out <= ~cmd_data_out;
    end
  end
  // Receiver: collects the reply, stalling every other cycle when slow.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      done_out <= 1'b0;
      rep_out <= '0;
      nrep_out <= 3'h0;
      rsp_ready_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      rsp_ready_out <= slow_in ? ~rsp_ready_out : 1'b1;
      if (go_in && !busy_r) begin
        busy_r <= 1'b1;
        rep_out <= '0;
        nrep_out <= 3'h0;
      end else if (quit_in) begin
        busy_r <= 1'b0;
      end else if (rsp_valid_in && rsp_ready_out) begin
        rep_out[8*nrep_out +: 8] <= rsp_data_in;
        nrep_out <= nrep_out + 3'h1;
        if ((nrep_out == 3'h0 && rsp_data_in == 8'hff) || nrep_out == 3'h4) begin
          busy_r <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // gci_host_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  // Clock, reset and register bus.
  logic                sys_clk_in = 1'b0;
  logic                rst_n_in = 1'b0;
  logic [3:0]          av_a = 4'h0;
  logic                av_rd = 1'b0;
  logic                av_wr = 1'b0;
  logic [31:0]         av_d = 32'h0;
  logic [3:0]          av_be = 4'hf;
  logic [31:0]         av_q;
  wire  [31:0]         av_rdata;
  wire                 av_wait;
  // Host streams and pads.
  wire  [7:0]          c_data, r_data, pin_out, pin_oe_n;
  wire                 c_valid, c_ready, r_valid, r_ready, h_done;
  wire  [39:0]         h_rep;
  wire  [2:0]          h_n;
  logic                h_go = 1'b0, h_slow = 1'b0, h_quit = 1'b0;
  gci_pkg::gci_frame_t h_frame = '0;
  logic [7:0]          pin_in = 8'h00;
  // Reference copy of the pin words, and the tallies.
  logic [7:0]          m_func, m_dir, m_lvl, m_st;
  int                  errors = 0, n_tests = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  gci_interp DUT (.sys_clk_in, .rst_n_in, .avs_address_in(av_a), .avs_read_in(av_rd),
    .avs_write_in(av_wr), .avs_writedata_in(av_d), .avs_byteenable_in(av_be),
    .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait), .cmd_data_in(c_data),
    .cmd_valid_in(c_valid), .cmd_ready_out(c_ready), .rsp_data_out(r_data),
    .rsp_valid_out(r_valid), .rsp_ready_in(r_ready), .pin_in, .pin_out, .pin_oe_n_out(pin_oe_n));
  gci_host_model u_host (.sys_clk_in, .rst_n_in, .go_in(h_go), .quit_in(h_quit),
    .slow_in(h_slow), .frame_in(h_frame), .done_out(h_done), .rep_out(h_rep), .nrep_out(h_n),
    .cmd_data_out(c_data), .cmd_valid_out(c_valid), .cmd_ready_in(c_ready),
    .rsp_data_in(r_data), .rsp_valid_in(r_valid), .rsp_ready_out(r_ready));
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reset for three cycles and reload the boot words.
  task automatic do_reset();
    ##1;
    rst_n_in <= 1'b0;
    {m_func, m_dir, m_lvl, m_st} = 32'hff00ff00;
    ##3;
    rst_n_in <= 1'b1;
  endtask
  // One bus cycle, held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be = 4'hf);
    int i;
    ##1;
    av_a <= a;
    av_d <= d;
    av_be <= be;
    av_wr <= wr;
    av_rd <= !wr;
    i = 0;
    do begin
      ##1;
      i++;
    end while (av_wait !== 1'b0 && i < 50);
    av_q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (i >= 50) begin
      errors++;
      finish_test();
    end
  endtask
  function automatic logic [7:0] upd(input logic [7:0] o, g, v);
    return (o & ~g) | (v & g);
  endfunction
  // Current state word: outputs from store, inputs from pads.
  function automatic logic [7:0] stn();
    return (m_dir & m_st) | (~m_dir & (pin_in ^ m_lvl));
  endfunction
  // Send one command through the host and judge the whole reply.
  task automatic cmd(input logic [7:0] op, input logic [31:0] mk, v, input bit off);
    logic [7:0] g, e;
    logic bad;
    int i;
    g = mk[7:0] & m_func;
    bad = !(op inside {[8'h10:8'h13], [8'h19:8'h1b]});
    case (op)
      8'h19: m_dir = upd(m_dir, g, v[7:0]);
      8'h1a: m_lvl = upd(m_lvl, g, v[7:0]);
      8'h1b: m_st = upd(m_st, g, v[7:0]);
      default: ;
    endcase
    case (op)
      8'h10: e = m_func;
      8'h11, 8'h19: e = m_dir;
      8'h12, 8'h1a: e = m_lvl;
      default: e = stn();
    endcase
    ##1;
    h_frame <= '{op, mk, v};
    h_go <= 1'b1;
    ##1;
    h_go <= 1'b0;
    i = 0;
    while (h_done !== 1'b1 && i < 80) begin
      ##1;
      i++;
    end
    if (off) begin
      `CHK(i, 80)
      h_quit <= 1'b1;
      ##1;
      h_quit <= 1'b0;
    end else if (i >= 80) begin
      errors++;
      finish_test();
    end else begin
      `CHK(h_n, bad ? 3'h1 : 3'h5)
      `CHK(h_rep, bad ? 40'hff : {24'h0, e, op})
      ##2;
      `CHK(pin_oe_n, ~(m_dir & m_func))
      `CHK(pin_out & m_dir, (m_st ^ m_lvl) & m_dir)
    end
  endtask
  // Boot words by bus and by every read opcode with junk parameters.
  task automatic t_boot();
    bus(1'b0, 4'h4, 32'h0);
    `CHK(av_q[7:0], 8'hff)
    bus(1'b0, 4'h8, 32'h0);
    `CHK(av_q, {8'h0, stn(), m_lvl, m_dir})
    for (int k = 0; k < 4; k++) cmd(8'h10 + k[7:0], 32'hffffffff, 32'ha5a5a5a5, 0);
  endtask
  // Masked updates with pads and a stalling host.
  task automatic t_set();
    pin_in <= 8'h30;
    h_slow <= 1'b1;
    cmd(8'h19, 32'hffffff0f, 32'h000000a5, 0);
    cmd(8'h19, 32'h0, 32'hffffffff, 0);
    cmd(8'h1b, 32'h01, 32'hff, 0);
    cmd(8'h1a, 32'h04, 32'h00, 0);
    cmd(8'h1b, 32'h05, 32'h04, 0);
    cmd(8'h13, 32'h0, 32'h0, 0);
    h_slow <= 1'b0;
  endtask
  // Unknown opcodes, back to back.
  task automatic t_bad();
    logic [7:0] ops[6] = '{8'h00, 8'h0f, 8'h14, 8'h18, 8'h1c, 8'hff};
    foreach (ops[k]) cmd(ops[k], 32'h0, 32'h0, 0);
  endtask
  // Dedicated pins are skipped by updates; no opcode touches the function word.
  task automatic t_func();
    bus(1'b1, 4'h4, 32'h00, 4'h0);
    bus(1'b1, 4'h4, 32'hfe);
    m_func = 8'hfe;
    cmd(8'h19, 32'hff, 32'h00, 0);
    cmd(8'h10, 32'hffffffff, 32'h0, 0);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    `CHK(av_q, {8'h0, stn(), m_lvl, m_dir})
    bus(1'b0, 4'h2, 32'h0);
    `CHK(av_q, 32'h0)
  endtask
  // Disabled interface gives no reply; enabled again it answers.
  task automatic t_off();
    bus(1'b1, 4'h0, 32'h1);
    cmd(8'h11, 32'h0, 32'h0, 1);
    bus(1'b1, 4'h0, 32'h0);
    cmd(8'h11, 32'h0, 32'h0, 0);
  endtask
  // A reset in mid-run restores the boot words.
  task automatic t_reset();
    do_reset();
    cmd(8'h12, 32'h0, 32'h0, 0);
    cmd(8'h11, 32'h0, 32'h0, 0);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(av_q[7:0], 8'hff)
  endtask
  initial begin
    do_reset();
    t_boot();
    t_set();
    t_bad();
    t_func();
    t_off();
    t_reset();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
